// [logic/fcg_defines.svh]
// constants for the flash control register access gate
// assumes an 8-bit cpu bus with 17-bit byte addresses
`ifndef FCG_DEFINES_SVH
`define FCG_DEFINES_SVH
`define FCG_ADDR_FLASH_CONTROL 17'h0FF80
`define FCG_ADDR_ERASE_ONE 17'h0FF82
`define FCG_ADDR_ERASE_TWO 17'h0FF83
`define FCG_ADDR_UNIMPL_LO 17'h0F780
`define FCG_ADDR_UNIMPL_HI 17'h1FFFF
`define FCG_RST_FLASH_CONTROL 8'h80
`define FCG_RST_ERASE 8'h00
`define FCG_ALL_ONES 8'hFF
`define FCG_HV_BIT 7
`endif

// [logic/fcg_pkg.sv]
// types for the flash control register access gate
// used with fcg_defines.svh
package fcg_pkg;
  typedef enum logic [1:0] {
    FCG_MODE_EXP_NOROM = 2'b01,
    FCG_MODE_EXP_ROM = 2'b10,
    FCG_MODE_SINGLE = 2'b11,
    FCG_MODE_WRITER = 2'b00
  } fcg_mode_t;
  typedef enum logic [1:0] {
    FCG_ROUTE_NONE = 2'b00,
    FCG_ROUTE_REG = 2'b01,
    FCG_ROUTE_ONES = 2'b10,
    FCG_ROUTE_EXT = 2'b11
  } fcg_route_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [16:0] addr;
    logic [7:0] wdata;
  } fcg_bus_req_t;
endpackage

// [logic/fcg_gate.sv]
// flash control register decode and access gate
// cpu bus is single-cycle on i_clock; hv and standby arrive from pins
`timescale 1ns/100ps
`include "fcg_defines.svh"
//
// Function
// - writer mode reads all ones from unimplemented range up to top.
// - high-voltage flag follows the pin threshold comparator output.
// - with flag set in rom-enabled expanded or single-chip mode, control and erase registers accept writes.
// - three registers decoded at fixed addresses, only with high voltage.
// - rom-disabled expanded mode: reserved all ones, else external space.
// - rom-enabled expanded mode: registers with hv, else external cycles.
// - single chip: control resets 0x80 with hv, else fixed all ones.
// - standby pin low forces hardware standby in every mode.
module fcg_gate (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_hv_detect,
  input wire logic i_standby_pin_n,
  input wire fcg_pkg::fcg_mode_t i_mode,
  input wire fcg_pkg::fcg_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  output logic o_ext_access,
  output logic o_hit,
  output logic o_hv_flag,
  output logic o_standby,
  output logic [7:0] o_flash_control,
  output logic [7:0] o_erase_block_select_one,
  output logic [7:0] o_erase_block_select_two
);
  logic hv_meta_q, hv_q, sb_meta_q, sb_q;
  logic hv_meta_d, hv_d, sb_meta_d, sb_d;
  logic [7:0] fc_q, fc_d, e1_q, e1_d, e2_q, e2_d, rd_q, rd_d;
  logic is_reg, is_unimpl;
  fcg_pkg::fcg_route_t route;

  // two flops on each pin; the first is read by nothing else
  always_comb begin
    hv_meta_d = i_hv_detect;
    hv_d = hv_meta_q;
    sb_meta_d = i_standby_pin_n;
    sb_d = sb_meta_q;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hv_meta_q <= 1'b0;
      hv_q <= 1'b0;
      sb_meta_q <= 1'b1;
      sb_q <= 1'b1;
    end else if (i_ce) begin
      hv_meta_q <= hv_meta_d;
      hv_q <= hv_d;
      sb_meta_q <= sb_meta_d;
      sb_q <= sb_d;
    end
  end

  assign is_reg = i_bus.addr == `FCG_ADDR_FLASH_CONTROL ||
                  i_bus.addr == `FCG_ADDR_ERASE_ONE ||
                  i_bus.addr == `FCG_ADDR_ERASE_TWO;
  assign is_unimpl = i_bus.addr >= `FCG_ADDR_UNIMPL_LO &&
                     i_bus.addr <= `FCG_ADDR_UNIMPL_HI;

  // route decision per mode and synchronised hv
  always_comb begin
    route = fcg_pkg::FCG_ROUTE_NONE;
    if (i_bus.req && sb_q) begin
      case (i_mode)
        fcg_pkg::FCG_MODE_EXP_NOROM: begin
          if (is_reg) begin
            route = hv_q ? fcg_pkg::FCG_ROUTE_ONES
                         : fcg_pkg::FCG_ROUTE_EXT;
          end
        end
        fcg_pkg::FCG_MODE_EXP_ROM: begin
          if (is_reg) begin
            route = hv_q ? fcg_pkg::FCG_ROUTE_REG
                         : fcg_pkg::FCG_ROUTE_EXT;
          end
        end
        fcg_pkg::FCG_MODE_SINGLE: begin
          if (is_reg) begin
            route = hv_q ? fcg_pkg::FCG_ROUTE_REG
                         : fcg_pkg::FCG_ROUTE_ONES;
          end
        end
        fcg_pkg::FCG_MODE_WRITER: begin
          // register window lies inside the unimplemented range
          if (is_unimpl) begin
            route = fcg_pkg::FCG_ROUTE_ONES;
          end
        end
        default: route = fcg_pkg::FCG_ROUTE_NONE;
      endcase
    end
  end

  // register writes and read data
  always_comb begin
    fc_d = fc_q;
    e1_d = e1_q;
    e2_d = e2_q;
    rd_d = rd_q;
    if (!sb_q) begin
      // standby resets the control state like a chip reset
      fc_d = `FCG_RST_FLASH_CONTROL;
      e1_d = `FCG_RST_ERASE;
      e2_d = `FCG_RST_ERASE;
    end else if (route == fcg_pkg::FCG_ROUTE_REG) begin
      if (i_bus.wr) begin
        // hv bit itself is hardware status, not writable
        case (i_bus.addr)
          `FCG_ADDR_FLASH_CONTROL: fc_d = {1'b1, i_bus.wdata[6:0]};
          `FCG_ADDR_ERASE_ONE: e1_d = i_bus.wdata;
          `FCG_ADDR_ERASE_TWO: e2_d = i_bus.wdata;
          default: fc_d = fc_q;
        endcase
      end else begin
        case (i_bus.addr)
          `FCG_ADDR_FLASH_CONTROL: rd_d = fc_q;
          `FCG_ADDR_ERASE_ONE: rd_d = e1_q;
          `FCG_ADDR_ERASE_TWO: rd_d = e2_q;
          default: rd_d = `FCG_ALL_ONES;
        endcase
      end
    end else if (route == fcg_pkg::FCG_ROUTE_ONES && !i_bus.wr) begin
      rd_d = `FCG_ALL_ONES;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fc_q <= `FCG_RST_FLASH_CONTROL;
      e1_q <= `FCG_RST_ERASE;
      e2_q <= `FCG_RST_ERASE;
      rd_q <= `FCG_ALL_ONES;
    end else if (i_ce) begin
      fc_q <= fc_d;
      e1_q <= e1_d;
      e2_q <= e2_d;
      rd_q <= rd_d;
    end
  end

  assign o_rdata = rd_q;
  assign o_ext_access = route == fcg_pkg::FCG_ROUTE_EXT;
  assign o_hit = route == fcg_pkg::FCG_ROUTE_REG ||
                 route == fcg_pkg::FCG_ROUTE_ONES;
  assign o_hv_flag = hv_q;
  assign o_standby = !sb_q;
  assign o_flash_control = fc_q;
  assign o_erase_block_select_one = e1_q;
  assign o_erase_block_select_two = e2_q;

  property p_hv_sync;
    @(posedge i_clock) disable iff (!i_rst_n)
    // both sync flops must have been enabled for the two-edge latency
    $past(i_ce) && $past(i_ce, 2) && $rose(o_hv_flag) |->
      $past(i_hv_detect, 2);
  endproperty
  a_hv_sync: assert property (p_hv_sync) else $error("hv not synced");

  property p_writer_ones;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && sb_q && i_mode == fcg_pkg::FCG_MODE_WRITER && i_bus.req &&
     !i_bus.wr && is_unimpl) |=> (o_rdata == `FCG_ALL_ONES);
  endproperty
  a_writer_ones: assert property (p_writer_ones)
    else $error("writer read not ones");

  sequence s_ctl_write;
    i_ce && sb_q && hv_q && i_bus.req && i_bus.wr &&
    i_mode == fcg_pkg::FCG_MODE_SINGLE &&
    i_bus.addr == `FCG_ADDR_ERASE_ONE;
  endsequence
  property p_write_taken;
    @(posedge i_clock) disable iff (!i_rst_n)
    s_ctl_write |=> (o_erase_block_select_one == $past(i_bus.wdata));
  endproperty
  a_write_taken: assert property (p_write_taken)
    else $error("erase write lost");

  property p_no_hv_frozen;
    @(posedge i_clock) disable iff (!i_rst_n)
    (!hv_q && sb_q) |=> $stable(o_flash_control);
  endproperty
  a_no_hv_frozen: assert property (p_no_hv_frozen)
    else $error("control changed without hv");

  property p_norom;
    @(posedge i_clock) disable iff (!i_rst_n)
    (sb_q && i_bus.req && is_reg && i_mode == fcg_pkg::FCG_MODE_EXP_NOROM)
    |-> (o_ext_access == !hv_q && o_hit == hv_q);
  endproperty
  a_norom: assert property (p_norom) else $error("mode 1 route");

  property p_rom;
    @(posedge i_clock) disable iff (!i_rst_n)
    (sb_q && i_bus.req && is_reg && i_mode == fcg_pkg::FCG_MODE_EXP_ROM)
    |-> (o_ext_access != hv_q);
  endproperty
  a_rom: assert property (p_rom) else $error("mode 2 route");

  property p_single_ones;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && sb_q && !hv_q && i_bus.req && !i_bus.wr && is_reg &&
     i_mode == fcg_pkg::FCG_MODE_SINGLE) |=> (o_rdata == `FCG_ALL_ONES);
  endproperty
  a_single_ones: assert property (p_single_ones)
    else $error("mode 3 not ones");

  property p_standby;
    @(posedge i_clock) disable iff (!i_rst_n)
    // sync flops hold reset values for two edges after release
    $past(i_rst_n, 2) && $past(i_ce) && $past(i_ce, 2) &&
    !$past(i_standby_pin_n, 2) |->
      (o_standby && !o_hit && !o_ext_access);
  endproperty
  a_standby: assert property (p_standby) else $error("standby missed");

  property p_hv_bit;
    @(posedge i_clock) disable iff (!i_rst_n)
    o_flash_control[`FCG_HV_BIT];
  endproperty
  a_hv_bit: assert property (p_hv_bit) else $error("hv bit cleared");
endmodule

// [testbench/fcg_supply_model.sv]
// programming supply and shared standby pin model for the access gate
// assumes the bench asks for rail changes only with program bits clear
`timescale 1ns/100ps
module fcg_supply_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_apply,
  input wire logic i_standby,
  output logic o_hv_detect,
  output logic o_standby_pin_n
);
  logic hv_q = 1'h0;
  int low_cnt = 0;
  // in reset the rail moves only after ten clocks low
  // out of reset it follows i_apply on every falling edge
  always @(negedge i_clock) begin
    low_cnt <= i_rst_n ? 0 : low_cnt + 1;
    if (i_rst_n || low_cnt >= 10)
      hv_q <= i_apply;
  end
  // pin pulled low means standby, so no high voltage then
  assign o_standby_pin_n = !i_standby;
  assign o_hv_detect = hv_q && !i_standby;
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the flash control access gate
// assumes fcg_gate plus the supply model; inputs move on falling edges
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic h;
    logic [1:0] m;
    logic w;
    logic [16:0] a;
    logic [7:0] d;
    logic [1:0] t;
  } fcg_row_t;
  logic i_clock = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_ce = 1'h1;
  logic apply = 1'h0;
  logic hardware_standby_pin = 1'h0;
  logic hv, hardware_standby_pin_n, hit, ext, hvf, sb;
  logic [7:0] rd, fc, e1, e2;
  fcg_pkg::fcg_bus_req_t bus = '0;
  fcg_pkg::fcg_mode_t mode = fcg_pkg::FCG_MODE_SINGLE;
  int fail_count = 0;
  int compares = 0;
  // hv, mode, write, address, data or expected read, {hit, ext}
  fcg_row_t rows [16] = '{
    '{1'h0, 2'h3, 1'h0, 17'h0FF80, 8'hFF, 2'h2},
    '{1'h0, 2'h3, 1'h1, 17'h0FF80, 8'h00, 2'h2},
    '{1'h0, 2'h3, 1'h0, 17'h0FF80, 8'hFF, 2'h2},
    '{1'h0, 2'h1, 1'h0, 17'h0FF82, 8'h00, 2'h1},
    '{1'h0, 2'h2, 1'h0, 17'h0FF83, 8'h00, 2'h1},
    '{1'h0, 2'h0, 1'h0, 17'h1FFFF, 8'hFF, 2'h2},
    '{1'h0, 2'h0, 1'h0, 17'h0F780, 8'hFF, 2'h2},
    '{1'h1, 2'h3, 1'h0, 17'h0FF80, 8'h80, 2'h2},
    '{1'h1, 2'h3, 1'h1, 17'h0FF82, 8'h5A, 2'h2},
    '{1'h1, 2'h3, 1'h1, 17'h0FF83, 8'hA5, 2'h2},
    '{1'h1, 2'h3, 1'h0, 17'h0FF82, 8'h5A, 2'h2},
    '{1'h1, 2'h2, 1'h1, 17'h0FF80, 8'h40, 2'h2},
    '{1'h1, 2'h2, 1'h0, 17'h0FF80, 8'hC0, 2'h2},
    '{1'h1, 2'h1, 1'h0, 17'h0FF80, 8'hFF, 2'h2},
    '{1'h1, 2'h0, 1'h0, 17'h0FF82, 8'hFF, 2'h2},
    '{1'h1, 2'h3, 1'h1, 17'h0FF80, 8'h00, 2'h2}
  };

  fcg_gate u_fcg_gate (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_hv_detect(hv), .i_standby_pin_n(hardware_standby_pin_n), .i_mode(mode),
    .i_bus(bus), .o_rdata(rd), .o_ext_access(ext), .o_hit(hit),
    .o_hv_flag(hvf), .o_standby(sb), .o_flash_control(fc),
    .o_erase_block_select_one(e1), .o_erase_block_select_two(e2));
  fcg_supply_model u_fcg_supply_model (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_apply(apply), .i_standby(hardware_standby_pin),
    .o_hv_detect(hv), .o_standby_pin_n(hardware_standby_pin_n));

  always #20 i_clock = ~i_clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one bus access; read data lands one edge later
  task automatic acc(input fcg_row_t r);
    mode = fcg_pkg::fcg_mode_t'(r.m);
    bus = '{1'h1, r.w, r.a, r.d};
    #1 chk({6'h00, hit, ext}, {6'h00, r.t});
    @(negedge i_clock);
    if (r.t[1] && !r.w) chk(rd, r.d);
  endtask

  initial begin
    #100000; // bounds any stuck program bit
    fail_count++;
    results();
  end

  initial begin
    repeat (4) @(negedge i_clock);
    chk(fc, 8'h80);
    chk(e1, 8'h00);
    chk(rd, 8'hFF);
    chk({7'h00, hvf}, 8'h00);
    i_rst_n = 1'h1;
    @(negedge i_clock);
    foreach (rows[i]) begin
      if (rows[i].h !== apply) begin
        // rows before a release leave the program bits clear
        bus.req = 1'h0;
        apply = rows[i].h;
        // supply reaches its range before any write
        repeat (5) @(negedge i_clock);
      end
      acc(rows[i]);
    end
    bus.req = 1'h0;
    apply = 1'h0;
    repeat (5) @(negedge i_clock);
    // flag only after two synchronising edges
    apply = 1'h1;
    @(posedge hv);
    @(negedge i_clock);
    chk({7'h00, hvf}, 8'h00);
    @(negedge i_clock);
    chk({7'h00, hvf}, 8'h01);
    // whole-byte compare, not the flag bit alone
    acc(fcg_row_t'{1'h1, 2'h3, 1'h0, 17'h0FF80, 8'h80, 2'h2});
    i_ce = 1'h0;
    bus = '{1'h1, 1'h1, 17'h0FF82, 8'h33};
    @(negedge i_clock);
    bus.req = 1'h0;
    i_ce = 1'h1;
    chk(e1, 8'h5A);
    chk(e2, 8'hA5);
    mode = fcg_pkg::FCG_MODE_WRITER;
    hardware_standby_pin = 1'h1;
    repeat (3) @(negedge i_clock);
    chk({7'h00, sb}, 8'h01);
    chk(e1, 8'h00);
    chk(e2, 8'h00);
    bus = '{1'h1, 1'h0, 17'h0FF80, 8'h00};
    #1 chk({6'h00, hit, ext}, 8'h00);
    @(negedge i_clock);
    bus.req = 1'h0;
    hardware_standby_pin = 1'h0;
    i_rst_n = 1'h0;
    repeat (12) @(negedge i_clock);
    chk(fc, 8'h80);
    chk(e2, 8'h00);
    chk(rd, 8'hFF);
    results();
  end
endmodule
